// *** core/ubrg_defines.svh ***
// Purpose: offsets, field positions, reset values and ratios of the baud generator
// Assumes: apb byte addressing, one 32-bit word per register
// Notes:   included by bare name
`ifndef UBRG_DEFINES_SVH
`define UBRG_DEFINES_SVH

// --------------------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------------------
`define UBRG_OFS_TXSC      12'h000
`define UBRG_OFS_RXSC      12'h004
`define UBRG_OFS_DIV       12'h008
`define UBRG_OFS_STAT      12'h00c

// --------------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------------
`define UBRG_TXSC_CLKSRC   7
`define UBRG_TXSC_SYNC     4
`define UBRG_TXSC_HSPEED   2
`define UBRG_TXSC_EMPTY    1
`define UBRG_RXSC_ENABLE   7

// --------------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------------
`define UBRG_TXSC_RESET    8'h02
`define UBRG_RXSC_RESET    8'h00
`define UBRG_DIV_RESET     8'h00
// writable bits of transmit_status_control (bit 3 unimplemented, bit 1 read-only)
`define UBRG_TXSC_WMASK    8'hf5
// writable bits of receive_status_control (low three unimplemented, read as zero)
`define UBRG_RXSC_WMASK    8'hf8

// --------------------------------------------------------------------------
// fixed prescale ratios, as terminal counts (ratio minus one)
// --------------------------------------------------------------------------
`define UBRG_PRE_LOW       6'h3f
`define UBRG_PRE_HIGH      6'h0f
`define UBRG_PRE_SYNC      6'h03

`endif

// *** core/ubrg_pkg.sv ***
// Purpose: types shared by the baud generator
// Assumes: nothing
// Notes:   constants live in ubrg_defines.svh
package ubrg_pkg;

    typedef enum logic [1:0] {
        UBRG_MODE_ASYNC_LOW,
        UBRG_MODE_ASYNC_HIGH,
        UBRG_MODE_SYNC
    } ubrg_mode_t;

    typedef struct packed {
        logic       bit_tick;
        logic       sample_tick;
        logic       rx_level;
        logic       clk_master;
    } ubrg_timing_t;

endpackage : ubrg_pkg

// *** core/ubrg_top.sv ***
// Purpose: baud rate generator of a serial port, with majority-vote receive sampling
// Assumes: apb slave on pclk; shift logic consumes the timing outputs
// Notes:   one pclk cycle stands for one oscillator period
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "ubrg_defines.svh"

module ubrg_top
    import ubrg_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        receive_data_pin,
    input  wire logic        tx_shift_empty,
    output logic             bit_tick,
    output logic             sample_tick,
    output logic             rx_level,
    output logic             clk_master,
    output ubrg_timing_t     timing
);

    // ----------------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------------
    logic [7:0]  txsc_ff;
    logic [7:0]  rxsc_ff;
    logic [7:0]  baud_divisor_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        empty_s1_ff;
    logic        empty_s2_ff;

    function automatic logic ubrg_mapped(input logic [11:0] a);
        ubrg_mapped = (a == `UBRG_OFS_TXSC) || (a == `UBRG_OFS_RXSC) ||
                      (a == `UBRG_OFS_DIV)  || (a == `UBRG_OFS_STAT);
    endfunction : ubrg_mapped

    logic acc;
    logic wr;
    assign acc = psel & penable;
    assign wr  = acc & pwrite & ubrg_mapped(paddr);

    // writes land at the access edge only, once ready is already high
    logic txsc_wr;
    logic rxsc_wr;
    assign txsc_wr = wr & pready_ff & (paddr == `UBRG_OFS_TXSC);
    assign rxsc_wr = wr & pready_ff & (paddr == `UBRG_OFS_RXSC);

    // zero-wait slave: pready rises in the access cycle itself
    // unmapped offsets answer with an error; their writes are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= psel & ~penable;
            pslverr_ff <= psel & ~penable & ~ubrg_mapped(paddr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txsc_ff <= `UBRG_TXSC_RESET;
        end else if (txsc_wr) begin
            txsc_ff <= (pwdata[7:0] & `UBRG_TXSC_WMASK) | {6'h00, empty_s2_ff, 1'b0};
        end else begin
            txsc_ff[`UBRG_TXSC_EMPTY] <= empty_s2_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxsc_ff <= `UBRG_RXSC_RESET;
        end else if (rxsc_wr) begin
            rxsc_ff <= pwdata[7:0] & `UBRG_RXSC_WMASK;
        end
    end

    logic div_wr;
    assign div_wr = wr & pready_ff & (paddr == `UBRG_OFS_DIV);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_divisor_ff <= `UBRG_DIV_RESET;
        end else if (div_wr) begin
            baud_divisor_ff <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // high, matching the empty flag's reset value, so bit 1 never dips
            empty_s1_ff <= 1'b1;
            empty_s2_ff <= 1'b1;
        end else begin
            empty_s1_ff <= tx_shift_empty;
            empty_s2_ff <= empty_s1_ff;
        end
    end

    // ----------------------------------------------------------------------
    // mode and prescale
    // ----------------------------------------------------------------------
    ubrg_mode_t mode;
    logic [5:0] pre_last;

    always_comb begin
        if (txsc_ff[`UBRG_TXSC_SYNC]) begin
            mode = UBRG_MODE_SYNC;
        end else if (txsc_ff[`UBRG_TXSC_HSPEED]) begin
            mode = UBRG_MODE_ASYNC_HIGH;
        end else begin
            mode = UBRG_MODE_ASYNC_LOW;
        end
    end

    always_comb begin
        unique case (mode)
            UBRG_MODE_ASYNC_LOW:  pre_last = `UBRG_PRE_LOW;
            UBRG_MODE_ASYNC_HIGH: pre_last = `UBRG_PRE_HIGH;
            UBRG_MODE_SYNC:       pre_last = `UBRG_PRE_SYNC;
            default:              pre_last = `UBRG_PRE_LOW;
        endcase
    end

    // ----------------------------------------------------------------------
    // baud timer
    // ----------------------------------------------------------------------
    // timer counts prescaled clock; the prescaler runs first so each timer
    // step lasts 4/16/64 clocks and the bit period is ratio*(divisor+1)
    logic [5:0] pre_ff;
    logic [7:0] timer_ff;
    logic       bit_tick_ff;
    logic       pre_wrap;
    logic       timer_wrap;
    logic       run;

    assign run        = rxsc_ff[`UBRG_RXSC_ENABLE];
    assign pre_wrap   = (pre_ff >= pre_last);
    assign timer_wrap = pre_wrap & (timer_ff == 8'h00);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_ff <= 6'h00;
        end else if (div_wr || !run) begin
            pre_ff <= 6'h00;
        end else if (pre_wrap) begin
            pre_ff <= 6'h00;
        end else begin
            pre_ff <= pre_ff + 6'h01;
        end
    end

    // down-counter reloads the divisor, so divisor 0 ticks every prescale period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_ff <= 8'h00;
        end else if (div_wr) begin
            timer_ff <= pwdata[7:0];
        end else if (!run) begin
            timer_ff <= baud_divisor_ff;
        end else if (timer_wrap) begin
            timer_ff <= baud_divisor_ff;
        end else if (pre_wrap) begin
            timer_ff <= timer_ff - 8'h01;
        end
    end

    logic master;
    // async has no external clock; in sync only clock-source set is internal
    assign master = ~txsc_ff[`UBRG_TXSC_SYNC] | txsc_ff[`UBRG_TXSC_CLKSRC];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_tick_ff <= 1'b0;
        end else begin
            bit_tick_ff <= run & master & timer_wrap & ~div_wr;
        end
    end

    // ----------------------------------------------------------------------
    // receive sampling
    // ----------------------------------------------------------------------
    logic       rx_s1_ff;
    logic       rx_s2_ff;
    logic [2:0] samp_ff;
    logic       rx_level_ff;
    logic       samp_tick_ff;
    logic       vote_now_ff;
    logic       samp_now;

    function automatic logic ubrg_major(input logic [2:0] s);
        ubrg_major = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
    endfunction : ubrg_major

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_s1_ff <= 1'b1;
            rx_s2_ff <= 1'b1;
        end else begin
            rx_s1_ff <= receive_data_pin;
            rx_s2_ff <= rx_s1_ff;
        end
    end

    // three samples taken on consecutive prescale steps; limitation: in any
    // mode the vote window covers three whole bits when divisor is 0
    assign samp_now = run & pre_wrap & (timer_ff <= 8'h02);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_ff <= 3'h7;
        end else if (samp_now) begin
            samp_ff <= {samp_ff[1:0], rx_s2_ff};
        end
    end

    // vote only once the bit's last sample is in, so with divisor 2 or more samples of two
    // different bits are never mixed into one decision
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_tick_ff <= 1'b0;
            vote_now_ff  <= 1'b0;
        end else begin
            samp_tick_ff <= samp_now;
            vote_now_ff  <= samp_now & (timer_ff == 8'h00);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_level_ff <= 1'b1;
        end else if (vote_now_ff) begin
            rx_level_ff <= ubrg_major(samp_ff);
        end
    end

    // ----------------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `UBRG_OFS_TXSC: prdata_ff <= {24'h00_0000, txsc_ff};
                `UBRG_OFS_RXSC: prdata_ff <= {24'h00_0000, rxsc_ff};
                `UBRG_OFS_DIV:  prdata_ff <= {24'h00_0000, baud_divisor_ff};
                `UBRG_OFS_STAT: prdata_ff <= {24'h00_0000, 2'h0, mode, rx_level_ff,
                                              master, run, bit_tick_ff};
                default:        prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    logic clk_master_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_master_ff <= 1'b0;
        end else begin
            clk_master_ff <= master;
        end
    end

    // ----------------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------------
    assign prdata      = prdata_ff;
    assign pready      = pready_ff;
    assign pslverr     = pslverr_ff;
    assign bit_tick    = bit_tick_ff;
    assign sample_tick = samp_tick_ff;
    assign rx_level    = rx_level_ff;
    assign clk_master  = clk_master_ff;
    assign timing      = '{bit_tick: bit_tick_ff, sample_tick: samp_tick_ff,
                           rx_level: rx_level_ff, clk_master: clk_master_ff};

endmodule : ubrg_top

`default_nettype wire

// *** verif/tb_top.sv ***
// Purpose: self-checking bench of the baud generator
// Assumes: one pclk stands for one oscillator period
// Notes:   fixed seed, random divisors among corner values
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin fail_count++; \
$display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module tb_top
    import ubrg_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic        bit_tick, rx_level, clk_master, rxd, rxq, txgo, empty;
    logic [11:0] paddr, ra [3] = '{12'h000, 12'h004, 12'h008};
    logic [31:0] pwdata, prdata, q, rr [3] = '{32'h02, 32'h0, 32'h0};
    logic [31:0] rw [3] = '{32'hf7, 32'hf8, 32'hff};
    logic [7:0]  x, md [4] = '{8'h00, 8'h04, 8'h90, 8'h94};
    int          fail_count, n_tests, c;
    ubrg_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .receive_data_pin(rxd),
        .tx_shift_empty(empty), .bit_tick(bit_tick), .sample_tick(),
        .rx_level(rx_level), .clk_master(clk_master), .timing());
    ubrg_peer i_peer (.pclk(pclk), .presetn(presetn), .bit_tick(bit_tick),
        .tx_start(txgo), .rx_req(rxq), .rx_pin(rxd), .tx_empty(empty));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic int per(input logic [7:0] t, input logic [7:0] d);
        return (t[4] ? 4 : (t[2] ? 16 : 64)) * (int'(d) + 1);
    endfunction : per
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wait_tick;
        c = 0;
        do @(posedge pclk); while (++c < 20000 && bit_tick !== 1'b1);
    endtask : wait_tick
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test
    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        #400000;
        fail_count++;
        finish_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, txgo} = 5'h00;
        {paddr, pwdata} = 44'h0;
        rxq = 1'b1;
        fail_count = 0;
        n_tests = 0;
        c = $urandom(41);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 3; i++) begin
            apb(0, ra[i], 0);
            `CHK("reset value", rr[i], q)
            apb(1, ra[i], 32'h1ff);
            apb(0, ra[i], 0);
            `CHK("read back", rw[i], q)
        end
        apb(1, 12'h010, 32'h1);
        `CHK("unmapped write", 1'b1, e)
        apb(0, 12'h010, 0);
        `CHK("unmapped read", 33'h100000000, {e, q})
        $display("test registers done");
        for (int m = 0; m < 4; m++) begin
            for (int j = 0; j < 3; j++) begin
                x = (j == 0) ? 8'h00 : ((j == 1) ? 8'hff : 8'($urandom % 64));
                apb(1, 12'h000, md[m]);
                apb(1, 12'h008, x);
                apb(0, 12'h00c, 0);
                `CHK("status", {md[m][4], ~md[m][4] & md[m][2], 1'b1}, {q[5:4], q[2]})
                wait_tick();
                wait_tick();
                `CHK("period", per(md[m], x), c)
            end
        end
        $display("test rates done");
        apb(1, 12'h000, 8'h10);
        c = 0;
        repeat (300) begin
            @(posedge pclk);
            if (bit_tick !== 1'b0) c++;
        end
        `CHK("slave ticks", 0, c)
        `CHK("master flag", 1'b0, clk_master)
        apb(1, 12'h000, 8'h00);
        apb(1, 12'h008, 8'hff);
        repeat (1000) @(posedge pclk);
        apb(1, 12'h008, 8'h00);
        wait_tick();
        `CHK("restart", 1'b1, c >= 63 && c <= 66)
        $display("test restart done");
        apb(1, 12'h000, 8'h90);
        txgo <= 1'b1;
        @(posedge pclk);
        txgo <= 1'b0;
        apb(1, 12'h000, 8'h92);
        apb(0, 12'h000, 0);
        `CHK("busy status", 32'h90, q)
        repeat (60) @(posedge pclk);
        apb(0, 12'h000, 0);
        `CHK("empty status", 32'h92, q)
        apb(1, 12'h008, 8'h05);
        c = 0;
        repeat (20) begin
            repeat (5 + $urandom % 20) @(posedge pclk);
            rxq <= 1'b0;
            @(posedge pclk);
            rxq <= 1'b1;
            repeat (8) begin
                @(posedge pclk);
                if (rx_level !== 1'b1) c++;
            end
        end
        `CHK("glitch votes", 0, c)
        rxq <= 1'b0;
        repeat (100) @(posedge pclk);
        `CHK("steady low", 1'b0, rx_level)
        $display("test sampling done");
        finish_test();
    end
endmodule : tb_top
`default_nettype wire

// *** verif/ubrg_peer.sv ***
// Purpose: shift-logic stand-in at the far side of the generator
// Assumes: a frame lasts ten bit ticks
// Notes:   receive pin follows the bench request
`timescale 1ns/10ps
`default_nettype none
module ubrg_peer (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic bit_tick,
    input  wire logic tx_start,
    input  wire logic rx_req,
    output logic      rx_pin,
    output logic      tx_empty
);
    logic [3:0] left_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            left_ff <= 4'h0;
        else if (tx_start)
            left_ff <= 4'ha;
        else if (bit_tick && left_ff != 4'h0)
            left_ff <= left_ff - 4'h1;
    end
    assign tx_empty = (left_ff == 4'h0);
    assign rx_pin   = rx_req;
endmodule : ubrg_peer
`default_nettype wire

// *** verif/ubrg_props.sv ***
// Purpose: port assertions of the baud generator
// Assumes: apb answers one cycle after setup
// Notes:   bound after endmodule
`timescale 1ns/10ps
`default_nettype none
module ubrg_props
    import ubrg_pkg::*;
(
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [11:0]  paddr,
    input wire logic         pready,
    input wire logic         pslverr,
    input wire logic         bit_tick,
    input wire logic         sample_tick,
    input wire logic         rx_level,
    input wire logic         clk_master,
    input wire ubrg_timing_t timing
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_ans; psel && !penable |=> pready; endproperty
    property p_one; pready |=> !pready; endproperty
    property p_gap; bit_tick |=> !bit_tick [*3]; endproperty
    property p_mst; !clk_master |-> !bit_tick; endproperty
    property p_bus; timing == {bit_tick, sample_tick, rx_level, clk_master}; endproperty
    property p_clr; pready && pwrite && paddr == 12'h008 |=> !bit_tick [*3]; endproperty
    property p_vote; $changed(rx_level) |-> $past(sample_tick); endproperty
    property p_map; pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 12'h00c); endproperty
    a_ans: assert property (p_ans) else $error("no answer after setup");
    a_one: assert property (p_one) else $error("ready longer than one cycle");
    a_gap: assert property (p_gap) else $error("ticks too close");
    a_mst: assert property (p_mst) else $error("tick while not master");
    a_bus: assert property (p_bus) else $error("timing struct differs");
    a_clr: assert property (p_clr) else $error("tick right after divisor write");
    a_vote: assert property (p_vote) else $error("level moved without sample");
    a_map: assert property (p_map) else $error("error flag wrong");
    c_tick: cover property (bit_tick);
    c_err: cover property (pslverr);
    c_vote: cover property ($fell(rx_level));
endmodule : ubrg_props
bind ubrg_top ubrg_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .bit_tick(bit_tick), .sample_tick(sample_tick),
    .rx_level(rx_level), .clk_master(clk_master), .timing(timing));
`default_nettype wire
